// *** bench/spm_far_side.sv ***
`timescale 1ns/1ps
module spm_far_side
  import spm_pkg::*;
(
  input wire logic clk_sys,
  input spm_mem_req_type memReq,
  output spm_mem_rsp_type memRsp,
  input wire logic mosiOut,
  output logic misoIn
);
  logic [7:0] mem [256];
  logic [1:0] lat = 2'h2;
  logic [1:0] dly = 2'h0;
  int nRd = 0;
  int nWr = 0;
  initial
    memRsp = '0;
  // Memory answers one byte per request after a delay; read data churns when idle.
  always @(posedge clk_sys) begin
    memRsp.ack <= 1'b0;
    memRsp.rdata <= ~memRsp.rdata;
    if (memReq.valid && !memRsp.ack) begin
      dly <= dly + 2'h1;
      if (dly >= lat) begin
        dly <= 2'h0;
        memRsp.ack <= 1'b1;
        if (memReq.write) begin
          mem[memReq.addr[7:0]] <= memReq.wdata;
          nWr <= nWr + 1;
        end else begin
          memRsp.rdata <= ~memReq.addr[7:0];
          nRd <= nRd + 1;
        end
      end
    end
  end
  // The slave echoes the master, so each stored byte shows what was sent.
  assign misoIn = mosiOut;
endmodule : spm_far_side

// *** bench/spm_master_unit_checker.sv ***
`timescale 1ns/1ps
module spm_master_unit_checker
  import spm_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input spm_mem_req_type memReq,
  input spm_mem_rsp_type memRsp,
  input wire logic sckOut,
  input wire logic mosiOut,
  input wire logic misoIn
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic acc = psel && penable;
  wire logic rdAcc = acc && !pwrite;
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access without ready");
  property p_trig; rdAcc && paddr == 12'h01C |-> prdata == 32'h0 && !pslverr; endproperty
  a_trig: assert property (p_trig) else $error("trigger read not zero");
  property p_flag; rdAcc && paddr inside {12'h104, 12'h110, 12'h118, 12'h120} |-> prdata[31:1] == 31'h0; endproperty
  a_flag: assert property (p_flag) else $error("flag upper bits set");
  property p_cnt; acc && pwrite && paddr == 12'h53C |-> !pslverr; endproperty
  a_cnt: assert property (p_cnt) else $error("count write refused");
  property p_hold; memReq.valid && !memRsp.ack |=> $stable(memReq); endproperty
  a_hold: assert property (p_hold) else $error("request moved before ack");
  property p_drop; memRsp.ack |=> !memReq.valid; endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_sck; memReq.valid && $past(memReq.valid) |-> $stable(sckOut); endproperty
  a_sck: assert property (p_sck) else $error("clock moved off byte boundary");
  property p_unm; acc && paddr == 12'h304 |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped access accepted");
  c_store: cover property (memReq.valid && memReq.write && memRsp.ack);
  c_fetch: cover property (memReq.valid && !memReq.write && memRsp.ack);
  c_err: cover property (acc && pslverr);
endmodule : spm_master_unit_checker

// *** bench/spm_master_unit_tb_top.sv ***
`timescale 1ns/1ps
module spm_master_unit_tb_top;
  logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sckOut, mosiOut, misoIn, err;
  logic [11:0] flags [5] = '{12'h104, 12'h110, 12'h118, 12'h120, 12'h14C};
  spm_pkg::spm_mem_req_type memReq;
  spm_pkg::spm_mem_rsp_type memRsp;
  int n_mismatch = 0;
  int n_compared = 0;
  always #25 clk_sys = ~clk_sys;
  spm_master_unit dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
    .memRsp(memRsp), .sckOut(sckOut), .mosiOut(mosiOut), .misoIn(misoIn));
  spm_far_side far (.clk_sys(clk_sys), .memReq(memReq), .memRsp(memRsp), .mosiOut(mosiOut), .misoIn(misoIn));
  task final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task hang();
    n_mismatch++;
    final_report();
  endtask : hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rc
  task waitf(input logic [11:0] a);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 400);
    if (rd[0] !== 1'b1)
      hang();
  endtask : waitf
  task go(input logic [7:0] rxl, input logic [7:0] txl);
    for (int i = 0; i < 256; i++)
      far.mem[i] = 8'hEE;
    far.nRd = 0;
    far.nWr = 0;
    foreach (flags[i])
      wr(flags[i], 32'h0);
    wr(12'h534, 32'h40);
    wr(12'h544, 32'h80);
    wr(12'h538, {24'h0, rxl});
    wr(12'h548, {24'h0, txl});
    wr(12'h010, 32'h1);
    waitf(12'h14C);
  endtask : go
  task chkx(input logic [7:0] rxl, input logic [7:0] txl);
    wr(12'h53C, 32'h9);
    rc("rx count", 12'h53C, rxl);
    rc("tx count", 12'h54C, txl);
    rc("rx done", 12'h110, 32'h1);
    rc("tx done", 12'h120, 32'h1);
    chk("fetches", far.nRd, txl);
    chk("stores", far.nWr, rxl);
    for (int i = 0; i < 4; i++)
      chk("rx byte", far.mem[8'h40 + i], i >= rxl ? 8'hEE : i < txl ? 8'h7F - 8'(i) : 8'h5A);
  endtask : chkx
  task t_xfer(input logic [7:0] rxl, input logic [7:0] txl);
    go(rxl, txl);
    wr(12'h538, 32'h7);
    wr(12'h544, 32'h20);
    waitf(12'h118);
    chkx(rxl, txl);
  endtask : t_xfer
  task t_pause();
    logic s;
    int n;
    go(8'h3, 8'h3);
    wr(12'h01C, 32'h1);
    repeat (100) @(posedge clk_sys);
    s = sckOut;
    n = 0;
    repeat (200) begin
      @(posedge clk_sys);
      if (sckOut !== s || memReq.valid !== 1'b0)
        n++;
    end
    chk("paused", n, 32'h0);
    wr(12'h020, 32'h1);
    waitf(12'h118);
    chkx(8'h3, 8'h3);
  endtask : t_pause
  task t_halt();
    go(8'h4, 8'h4);
    wr(12'h014, 32'h1);
    waitf(12'h104);
    rc("rx done", 12'h110, 32'h1);
    rc("tx done", 12'h120, 32'h1);
    rc("both done", 12'h118, 32'h0);
    apb(1'b0, 12'h53C, 32'h0);
    chk("cut short", rd < 4, 32'h1);
  endtask : t_halt
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (flags[i])
      rc("flag reset", flags[i], 32'h0);
    rc("pause read", 12'h01C, 32'h0);
    apb(1'b0, 12'h304, 32'h0);
    chk("unmapped", err, 32'h1);
    wr(12'h104, 32'h1);
    rc("halted write", 12'h104, 32'h1);
    wr(12'h524, 32'h4);
    wr(12'h5C0, 32'h5A);
    wr(12'h554, 32'h0);
    wr(12'h500, 32'h7);
    t_xfer(8'h3, 8'h1);
    far.lat = 2'h0;
    t_xfer(8'h1, 8'h3);
    t_xfer(8'h2, 8'h2);
    t_pause();
    t_halt();
    wr(12'h554, 32'h7);
    t_xfer(8'h2, 8'h3);
    chk("idle clock", sckOut, 32'h1);
    final_report();
  end
endmodule : spm_master_unit_tb_top
bind spm_master_unit spm_master_unit_checker #(.CNT_W(CNT_W)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .memReq(memReq), .memRsp(memRsp), .sckOut(sckOut),
  .mosiOut(mosiOut), .misoIn(misoIn));

// *** verilog/spm_master_unit.sv ***
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_master_unit
  import spm_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output spm_mem_req_type memReq,
  input spm_mem_rsp_type memRsp,
  output logic sckOut,
  output logic mosiOut,
  input wire logic misoIn
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
      $error("CNT_W must lie between 1 and 16.");
    end
  endgenerate

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic apbSetup;
  logic apbWrite;

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign pready = 1'b1;

  function automatic logic wrHit(input logic [11:0] off, input logic we, input logic [11:0] adr);
    return we && (adr == off);
  endfunction : wrHit

  function automatic logic [11:0] flagOff(input int i);
    logic [11:0] o;
    o = `SPM_OFF_F_HALTED;
    case (i)
      `SPM_FL_RXDONE: o = `SPM_OFF_F_RXDONE;
      `SPM_FL_BOTH: o = `SPM_OFF_F_BOTH;
      `SPM_FL_TXDONE: o = `SPM_OFF_F_TXDONE;
      `SPM_FL_BEGAN: o = `SPM_OFF_F_BEGAN;
      default: o = `SPM_OFF_F_HALTED;
    endcase
    return o;
  endfunction : flagOff

  logic taskBegin;
  logic taskHalt;
  logic taskPause;
  logic taskCont;

  assign taskBegin = wrHit(`SPM_OFF_BEGIN, apbWrite, paddr) & pwdata[`SPM_TRIG_BIT];
  assign taskHalt = wrHit(`SPM_OFF_HALT, apbWrite, paddr) & pwdata[`SPM_TRIG_BIT];
  assign taskPause = wrHit(`SPM_OFF_PAUSE, apbWrite, paddr) & pwdata[`SPM_TRIG_BIT];
  assign taskCont = wrHit(`SPM_OFF_CONT, apbWrite, paddr) & pwdata[`SPM_TRIG_BIT];

  // ----------------------------------------
  // Software settings
  // ----------------------------------------
  logic event_task_shortcuts_reg, event_task_shortcuts_next;
  logic [3:0] on_reg, on_next;
  logic [31:0] pinClk_reg, pinClk_next;
  logic [31:0] pinOut_reg, pinOut_next;
  logic [31:0] pinIn_reg, pinIn_next;
  logic [31:0] rate_reg, rate_next;
  logic [31:0] rxPtr_reg, rxPtr_next;
  logic [CNT_W-1:0] rxLim_reg, rxLim_next;
  logic [1:0] rxList_reg, rxList_next;
  logic [31:0] txPtr_reg, txPtr_next;
  logic [CNT_W-1:0] txLim_reg, txLim_next;
  logic [1:0] txList_reg, txList_next;
  logic [2:0] cfg_reg, cfg_next;
  logic [7:0] fill_reg, fill_next;

  always_comb begin
    event_task_shortcuts_next = event_task_shortcuts_reg;
    on_next = on_reg;
    pinClk_next = pinClk_reg;
    pinOut_next = pinOut_reg;
    pinIn_next = pinIn_reg;
    rate_next = rate_reg;
    rxPtr_next = rxPtr_reg;
    rxLim_next = rxLim_reg;
    rxList_next = rxList_reg;
    txPtr_next = txPtr_reg;
    txLim_next = txLim_reg;
    txList_next = txList_reg;
    cfg_next = cfg_reg;
    fill_next = fill_reg;
    if (apbWrite) begin
      unique case (paddr)
        `SPM_OFF_EVENT_TASK_SHORTCUTS: event_task_shortcuts_next = pwdata[0];
        `SPM_OFF_ON: on_next = pwdata[3:0];
        `SPM_OFF_PIN_CLK: pinClk_next = pwdata;
        `SPM_OFF_PIN_OUT: pinOut_next = pwdata;
        `SPM_OFF_PIN_IN: pinIn_next = pwdata;
        `SPM_OFF_RATE: rate_next = pwdata;
        `SPM_OFF_RX_PTR: rxPtr_next = pwdata;
        `SPM_OFF_RX_LIM: rxLim_next = pwdata[CNT_W-1:0];
        `SPM_OFF_RX_LIST: rxList_next = pwdata[1:0];
        `SPM_OFF_TX_PTR: txPtr_next = pwdata;
        `SPM_OFF_TX_LIM: txLim_next = pwdata[CNT_W-1:0];
        `SPM_OFF_TX_LIST: txList_next = pwdata[1:0];
        `SPM_OFF_CFG: cfg_next = pwdata[2:0];
        `SPM_OFF_FILL: fill_next = pwdata[7:0];
        default: event_task_shortcuts_next = event_task_shortcuts_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      event_task_shortcuts_reg <= 1'b0;
      on_reg <= '0;
      pinClk_reg <= `SPM_ZERO32;
      pinOut_reg <= `SPM_ZERO32;
      pinIn_reg <= `SPM_ZERO32;
      rate_reg <= `SPM_ZERO32;
      rxPtr_reg <= `SPM_ZERO32;
      rxLim_reg <= '0;
      rxList_reg <= '0;
      txPtr_reg <= `SPM_ZERO32;
      txLim_reg <= '0;
      txList_reg <= '0;
      cfg_reg <= '0;
      fill_reg <= '0;
    end else begin
      event_task_shortcuts_reg <= event_task_shortcuts_next;
      on_reg <= on_next;
      pinClk_reg <= pinClk_next;
      pinOut_reg <= pinOut_next;
      pinIn_reg <= pinIn_next;
      rate_reg <= rate_next;
      rxPtr_reg <= rxPtr_next;
      rxLim_reg <= rxLim_next;
      rxList_reg <= rxList_next;
      txPtr_reg <= txPtr_next;
      txLim_reg <= txLim_next;
      txList_reg <= txList_next;
      cfg_reg <= cfg_next;
      fill_reg <= fill_next;
    end
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  spm_state_type st_reg, st_next;
  logic [31:0] wRxPtr_reg, wRxPtr_next;
  logic [31:0] wTxPtr_reg, wTxPtr_next;
  logic [CNT_W-1:0] wRxLim_reg, wRxLim_next;
  logic [CNT_W-1:0] wTxLim_reg, wTxLim_next;
  logic [CNT_W-1:0] rxCnt_reg, rxCnt_next;
  logic [CNT_W-1:0] txCnt_reg, txCnt_next;
  logic rxHit_reg, rxHit_next;
  logic txHit_reg, txHit_next;
  logic halt_reg, halt_next;
  logic pause_reg, pause_next;
  logic short_reg, short_next;
  logic engGo_reg, engGo_next;
  logic [7:0] txByte_reg, txByte_next;
  spm_mem_req_type mem_reg, mem_next;
  logic [`SPM_FL_NUM-1:0] flagSet;
  logic startReq;
  logic rxEnd;
  logic txEnd;
  logic engDone;
  logic [7:0] engRx;

  assign startReq = (taskBegin | short_reg) & (on_reg == `SPM_ON_VALUE);
  assign rxEnd = rxCnt_reg >= wRxLim_reg;
  assign txEnd = txCnt_reg >= wTxLim_reg;

  always_comb begin
    st_next = st_reg;
    wRxPtr_next = wRxPtr_reg;
    wTxPtr_next = wTxPtr_reg;
    wRxLim_next = wRxLim_reg;
    wTxLim_next = wTxLim_reg;
    rxCnt_next = rxCnt_reg;
    txCnt_next = txCnt_reg;
    rxHit_next = rxHit_reg;
    txHit_next = txHit_reg;
    short_next = 1'b0;
    engGo_next = 1'b0;
    txByte_next = txByte_reg;
    mem_next = mem_reg;
    flagSet = '0;
    halt_next = halt_reg | (taskHalt & (st_reg != ST_IDLE));
    pause_next = pause_reg | (taskPause & (st_reg != ST_IDLE));
    unique case (st_reg)
      ST_IDLE: begin
        flagSet[`SPM_FL_HALTED] = taskHalt;
        if (startReq) begin
          wRxPtr_next = rxPtr_reg;
          wTxPtr_next = txPtr_reg;
          wRxLim_next = rxLim_reg;
          wTxLim_next = txLim_reg;
          rxCnt_next = '0;
          txCnt_next = '0;
          rxHit_next = 1'b0;
          txHit_next = 1'b0;
          halt_next = 1'b0;
          pause_next = 1'b0;
          flagSet[`SPM_FL_BEGAN] = 1'b1;
          st_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (rxEnd && !rxHit_reg) begin
          rxHit_next = 1'b1;
          flagSet[`SPM_FL_RXDONE] = 1'b1;
        end
        if (txEnd && !txHit_reg) begin
          txHit_next = 1'b1;
          flagSet[`SPM_FL_TXDONE] = 1'b1;
        end
        if (rxEnd && txEnd) begin
          flagSet[`SPM_FL_BOTH] = 1'b1;
          flagSet[`SPM_FL_HALTED] = halt_reg;
          short_next = event_task_shortcuts_reg;
          halt_next = 1'b0;
          st_next = ST_IDLE;
        end else if (halt_reg) begin
          flagSet[`SPM_FL_RXDONE] = ~rxHit_reg;
          flagSet[`SPM_FL_TXDONE] = ~txHit_reg;
          rxHit_next = 1'b1;
          txHit_next = 1'b1;
          flagSet[`SPM_FL_HALTED] = 1'b1;
          halt_next = 1'b0;
          pause_next = 1'b0;
          st_next = ST_IDLE;
        end else if (pause_reg) begin
          st_next = ST_PAUSED;
        end else if (!txEnd) begin
          mem_next.valid = 1'b1;
          mem_next.write = 1'b0;
          mem_next.addr = wTxPtr_reg + 32'(txCnt_reg);
          mem_next.wdata = '0;
          st_next = ST_FETCH;
        end else begin
          txByte_next = fill_reg;
          engGo_next = 1'b1;
          st_next = ST_SHIFT;
        end
      end
      ST_PAUSED: begin
        if (taskCont || halt_reg) begin
          pause_next = 1'b0;
          st_next = ST_CHECK;
        end
      end
      ST_FETCH: begin
        if (memRsp.ack) begin
          mem_next.valid = 1'b0;
          txByte_next = memRsp.rdata;
          txCnt_next = txCnt_reg + CNT_W'(1);
          engGo_next = 1'b1;
          st_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (engDone) begin
          if (!rxEnd) begin
            mem_next.valid = 1'b1;
            mem_next.write = 1'b1;
            mem_next.addr = wRxPtr_reg + 32'(rxCnt_reg);
            mem_next.wdata = engRx;
            st_next = ST_STORE;
          end else begin
            st_next = ST_CHECK;
          end
        end
      end
      ST_STORE: begin
        if (memRsp.ack) begin
          mem_next.valid = 1'b0;
          rxCnt_next = rxCnt_reg + CNT_W'(1);
          st_next = ST_CHECK;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_IDLE;
      wRxPtr_reg <= `SPM_ZERO32;
      wTxPtr_reg <= `SPM_ZERO32;
      wRxLim_reg <= '0;
      wTxLim_reg <= '0;
      rxCnt_reg <= '0;
      txCnt_reg <= '0;
      rxHit_reg <= 1'b0;
      txHit_reg <= 1'b0;
      halt_reg <= 1'b0;
      pause_reg <= 1'b0;
      short_reg <= 1'b0;
      engGo_reg <= 1'b0;
      txByte_reg <= '0;
      mem_reg <= '0;
    end else begin
      st_reg <= st_next;
      wRxPtr_reg <= wRxPtr_next;
      wTxPtr_reg <= wTxPtr_next;
      wRxLim_reg <= wRxLim_next;
      wTxLim_reg <= wTxLim_next;
      rxCnt_reg <= rxCnt_next;
      txCnt_reg <= txCnt_next;
      rxHit_reg <= rxHit_next;
      txHit_reg <= txHit_next;
      halt_reg <= halt_next;
      pause_reg <= pause_next;
      short_reg <= short_next;
      engGo_reg <= engGo_next;
      txByte_reg <= txByte_next;
      mem_reg <= mem_next;
    end
  end

  assign memReq = mem_reg;

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  logic [`SPM_FL_NUM-1:0] flag_reg, flag_next;

  always_comb begin
    for (int i = 0; i < `SPM_FL_NUM; i++) begin
      flag_next[i] = flag_reg[i];
      if (wrHit(flagOff(i), apbWrite, paddr)) begin
        flag_next[i] = pwdata[0];
      end
      if (flagSet[i]) begin
        flag_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ----------------------------------------
  // Serial link
  // ----------------------------------------
  logic misoSync;
  spm_link_cfg_type linkCfg;

  assign linkCfg.cpol = cfg_reg[`SPM_CFG_CPOL];
  assign linkCfg.cpha = cfg_reg[`SPM_CFG_CPHA];
  assign linkCfg.lsbFirst = cfg_reg[`SPM_CFG_LSB];
  assign linkCfg.halfDiv = rate_reg[7:0];

  spm_sync2 #(
    .W(1)
  ) u_miso_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .din(misoIn),
    .dout(misoSync)
  );

  spm_shift_engine u_engine (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(engGo_reg),
    .txByte(txByte_reg),
    .cfg(linkCfg),
    .misoSync(misoSync),
    .sck(sckOut),
    .mosi(mosiOut),
    .done(engDone),
    .rxByte(engRx)
  );

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  logic [31:0] rd_reg, rd_next;
  logic err_reg, err_next;

  always_comb begin
    rd_next = `SPM_ZERO32;
    err_next = 1'b0;
    unique case (paddr)
      `SPM_OFF_BEGIN, `SPM_OFF_HALT, `SPM_OFF_PAUSE, `SPM_OFF_CONT: rd_next = `SPM_ZERO32;
      `SPM_OFF_F_HALTED: rd_next = 32'(flag_reg[`SPM_FL_HALTED]);
      `SPM_OFF_F_RXDONE: rd_next = 32'(flag_reg[`SPM_FL_RXDONE]);
      `SPM_OFF_F_BOTH: rd_next = 32'(flag_reg[`SPM_FL_BOTH]);
      `SPM_OFF_F_TXDONE: rd_next = 32'(flag_reg[`SPM_FL_TXDONE]);
      `SPM_OFF_F_BEGAN: rd_next = 32'(flag_reg[`SPM_FL_BEGAN]);
      `SPM_OFF_EVENT_TASK_SHORTCUTS: rd_next = 32'(event_task_shortcuts_reg);
      `SPM_OFF_ON: rd_next = 32'(on_reg);
      `SPM_OFF_PIN_CLK: rd_next = pinClk_reg;
      `SPM_OFF_PIN_OUT: rd_next = pinOut_reg;
      `SPM_OFF_PIN_IN: rd_next = pinIn_reg;
      `SPM_OFF_RATE: rd_next = rate_reg;
      `SPM_OFF_RX_PTR: rd_next = rxPtr_reg;
      `SPM_OFF_RX_LIM: rd_next = 32'(rxLim_reg);
      `SPM_OFF_RX_CNT: rd_next = 32'(rxCnt_reg);
      `SPM_OFF_RX_LIST: rd_next = 32'(rxList_reg);
      `SPM_OFF_TX_PTR: rd_next = txPtr_reg;
      `SPM_OFF_TX_LIM: rd_next = 32'(txLim_reg);
      `SPM_OFF_TX_CNT: rd_next = 32'(txCnt_reg);
      `SPM_OFF_TX_LIST: rd_next = 32'(txList_reg);
      `SPM_OFF_CFG: rd_next = 32'(cfg_reg);
      `SPM_OFF_FILL: rd_next = 32'(fill_reg);
      default: err_next = 1'b1;
    endcase
    if (!apbSetup) begin
      rd_next = rd_reg;
      err_next = err_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg <= `SPM_ZERO32;
      err_reg <= 1'b0;
    end else begin
      rd_reg <= rd_next;
      err_reg <= err_next;
    end
  end

  assign prdata = rd_reg;
  assign pslverr = err_reg;

endmodule : spm_master_unit

// *** verilog/spm_pkg.sv ***
package spm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_FETCH,
    ST_SHIFT,
    ST_STORE,
    ST_PAUSED
  } spm_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [7:0] wdata;
  } spm_mem_req_type;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } spm_mem_rsp_type;

  typedef struct packed {
    logic cpol;
    logic cpha;
    logic lsbFirst;
    logic [7:0] halfDiv;
  } spm_link_cfg_type;

endpackage : spm_pkg

// *** verilog/spm_regs.svh ***
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

`define SPM_OFF_BEGIN 12'h010
`define SPM_OFF_HALT 12'h014
`define SPM_OFF_PAUSE 12'h01C
`define SPM_OFF_CONT 12'h020
`define SPM_OFF_F_HALTED 12'h104
`define SPM_OFF_F_RXDONE 12'h110
`define SPM_OFF_F_BOTH 12'h118
`define SPM_OFF_F_TXDONE 12'h120
`define SPM_OFF_F_BEGAN 12'h14C
`define SPM_OFF_EVENT_TASK_SHORTCUTS 12'h200
`define SPM_OFF_ON 12'h500
`define SPM_OFF_PIN_CLK 12'h508
`define SPM_OFF_PIN_OUT 12'h50C
`define SPM_OFF_PIN_IN 12'h510
`define SPM_OFF_RATE 12'h524
`define SPM_OFF_RX_PTR 12'h534
`define SPM_OFF_RX_LIM 12'h538
`define SPM_OFF_RX_CNT 12'h53C
`define SPM_OFF_RX_LIST 12'h540
`define SPM_OFF_TX_PTR 12'h544
`define SPM_OFF_TX_LIM 12'h548
`define SPM_OFF_TX_CNT 12'h54C
`define SPM_OFF_TX_LIST 12'h550
`define SPM_OFF_CFG 12'h554
`define SPM_OFF_FILL 12'h5C0

`define SPM_TRIG_BIT 0
`define SPM_FL_HALTED 0
`define SPM_FL_RXDONE 1
`define SPM_FL_BOTH 2
`define SPM_FL_TXDONE 3
`define SPM_FL_BEGAN 4
`define SPM_FL_NUM 5

`define SPM_CFG_LSB 0
`define SPM_CFG_CPHA 1
`define SPM_CFG_CPOL 2
`define SPM_ON_VALUE 4'h7
`define SPM_MIN_HALF 8'h04
`define SPM_LAST_EDGE 4'hF
`define SPM_ZERO32 32'h00000000

`endif

// *** verilog/spm_shift_engine.sv ***
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_shift_engine
  import spm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [7:0] txByte,
  input spm_link_cfg_type cfg,
  input wire logic misoSync,
  output logic sck,
  output logic mosi,
  output logic done,
  output logic [7:0] rxByte
);

  function automatic logic pickBit(input logic [7:0] b, input logic lsb, input logic [2:0] i);
    return lsb ? b[i] : b[3'd7 - i];
  endfunction : pickBit

  logic busy_reg, busy_next;
  logic sck_reg, sck_next;
  logic mosi_reg, mosi_next;
  logic done_reg, done_next;
  logic [7:0] half_reg, half_next;
  logic [3:0] edge_reg, edge_next;
  logic [3:0] outIdx_reg, outIdx_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] rx_reg, rx_next;
  spm_link_cfg_type cfg_reg, cfg_next;

  always_comb begin
    busy_next = busy_reg;
    sck_next = sck_reg;
    mosi_next = mosi_reg;
    done_next = 1'b0;
    half_next = half_reg;
    edge_next = edge_reg;
    outIdx_next = outIdx_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    cfg_next = cfg_reg;
    if (!busy_reg) begin
      sck_next = cfg.cpol;
      if (start) begin
        busy_next = 1'b1;
        cfg_next = cfg;
        if (cfg.halfDiv < `SPM_MIN_HALF) begin
          cfg_next.halfDiv = `SPM_MIN_HALF;
        end
        tx_next = txByte;
        half_next = '0;
        edge_next = '0;
        outIdx_next = cfg.cpha ? 4'h0 : 4'h1;
        mosi_next = pickBit(txByte, cfg.lsbFirst, 3'h0);
      end
    end else if (half_reg == cfg_reg.halfDiv - 8'h01) begin
      half_next = '0;
      sck_next = ~sck_reg;
      edge_next = edge_reg + 4'h1;
      if (edge_reg[0] == cfg_reg.cpha) begin
        rx_next = cfg_reg.lsbFirst ? {misoSync, rx_reg[7:1]} : {rx_reg[6:0], misoSync};
      end else begin
        mosi_next = pickBit(tx_reg, cfg_reg.lsbFirst, outIdx_reg[2:0]);
        outIdx_next = outIdx_reg + 4'h1;
      end
      if (edge_reg == `SPM_LAST_EDGE) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end else begin
      half_next = half_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      sck_reg <= 1'b0;
      mosi_reg <= 1'b0;
      done_reg <= 1'b0;
      half_reg <= '0;
      edge_reg <= '0;
      outIdx_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      cfg_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      sck_reg <= sck_next;
      mosi_reg <= mosi_next;
      done_reg <= done_next;
      half_reg <= half_next;
      edge_reg <= edge_next;
      outIdx_reg <= outIdx_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      cfg_reg <= cfg_next;
    end
  end

  assign sck = sck_reg;
  assign mosi = mosi_reg;
  assign done = done_reg;
  assign rxByte = rx_reg;

endmodule : spm_shift_engine

// *** verilog/spm_sync2.sv ***
`timescale 1ns/1ps
module spm_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;

endmodule : spm_sync2
